// ---- dv/cmcr_bank_tb_top.sv ----
// self-checking bench for the converter misc control register bank
`timescale 1ns/1ns
`default_nettype none
module cmcr_bank_tb_top
  import cmcr_pkg::*;
;
  // ****************************************
  // signals and model state
  // ****************************************
  logic pclk = 1'b0;
  logic presetn, ce, psel, penable, pwrite;
  logic [CMCR_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr;
  logic [7:0] fuse_trim_b, trim_out, mf_count;
  logic [11:0] sample_in = 12'h000;
  logic timestamp_pin = 1'b0;
  logic sysref_pin = 1'b0;
  logic sample_8bit;
  logic [11:0] sample_out, e12, msk;
  logic dith_en, dith_amp, dith_rnd, link_rst_n, ser_pd, link_ce;
  logic [1:0] ila_bits;
  // register model, in table order: trim, dither, lsb control, link
  logic [7:0] m [4];
  logic [9:0] idx_tab [4] = '{CMCR_IDX_TRIM_B, CMCR_IDX_DITHER,
    CMCR_IDX_LSB_CTRL, CMCR_IDX_LINK_EN};
  // input history, newest first, for the sample path model
  logic [11:0] sh [$];
  logic th [$];
  logic cmp_on, ts_on;
  logic [31:0] seed, s2 = 32'h8B7A3413;
  logic [31:0] d;
  logic e;
  logic [19:0] snap; // counter and sample seen when ce falls
  int mismatches = 0;
  int check_count = 0;
  // free running 25 MHz clock
  always #20 pclk = ~pclk;
  cmcr_bank dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fuse_trim_b(fuse_trim_b), .sample_in(sample_in),
    .sample_8bit(sample_8bit), .timestamp_pin(timestamp_pin),
    .sysref_pin(sysref_pin), .sample_out(sample_out),
    .input_b_termination_trim_field(trim_out),
    .dither_enable_bit(dith_en), .dither_amplitude_select(dith_amp),
    .dither_rounding_select(dith_rnd), .link_reset_n(link_rst_n),
    .serializer_power_down(ser_pd), .link_clock_enable(link_ce),
    .ila_control_bits(ila_bits), .multiframe_counter(mf_count));
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    t = t ^ (t << 5);
    return t;
  endfunction
  // one comparison, four-state exact
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input string what);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // apb transfer; an edge passes first so psel is never assigned twice
  task automatic apb(input logic w, input logic [9:0] idx,
    input logic [7:0] wd, output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    // no wait count assumed; only the watchdog ends a stuck access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input int k, input logic [7:0] v);
    apb(1'b1, idx_tab[k], v, d, e);
    m[k] = v;
  endtask
  task automatic rdchk(input int k);
    apb(1'b0, idx_tab[k], 8'h00, d, e);
    chk(d, {24'h000000, m[k]}, "read back");
    chk(e, 1'b0, "read err");
  endtask
  // control outputs against the model, after they have settled
  task automatic check_ctrl();
    chk(trim_out, m[0], "trim out");
    chk(dith_en, m[1][0], "dither en");
    chk(dith_amp, m[1][1], "dither amp");
    chk(dith_rnd, m[1][2], "dither rnd");
    chk(link_rst_n, m[3][0], "link reset");
    chk(ser_pd, !m[3][0], "serializer");
    chk(link_ce, m[3][0], "link clock");
    chk(ila_bits, 2'h0, "ila bits");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ****************************************
  // stimulus and checking processes
  // ****************************************
  // random sample, marker and sysref traffic on every rising edge
  always @(posedge pclk) begin
    s2 = xs(s2);
    sample_in <= s2[11:0];
    timestamp_pin <= s2[12];
    sysref_pin <= s2[13];
  end
  // samples take 5 cycles, the marker 2 more for its synchroniser
  always @(negedge pclk) begin
    sh.push_front(sample_in);
    th.push_front(timestamp_pin);
    if (sh.size() > 8) begin
      void'(sh.pop_back());
      void'(th.pop_back());
    end
    if (cmp_on && sh.size() == 8) begin
      e12 = sh[5];
      if (ts_on)
        e12[sample_8bit ? 4 : 0] = th[7];
      // in 8-bit mode only the top byte carries data
      msk = sample_8bit ? 12'hFF0 : 12'hFFF;
      chk(sample_out & msk, e12 & msk, "sample");
      chk(ila_bits, 2'h0, "ila stream");
    end
  end
  // watchdog, well beyond the few hundred cycles the tests need
  initial begin
    #(40 * 8000);
    mismatches++;
    $display("unexpected at %0t: watchdog", $time);
    summarize();
  end
  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    sample_8bit = 1'b0;
    cmp_on = 1'b0;
    ts_on = 1'b0;
    seed = xs(32'h8B7A3413);
    fuse_trim_b = seed[7:0];
    m = '{seed[7:0], CMCR_RST_DITHER, CMCR_RST_LSB_CTRL, CMCR_RST_LINK_EN};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    check_ctrl();
    for (int k = 0; k < 4; k++)
      rdchk(k);
    $display("test reset done");
    // every dither code, then random words into every register
    for (int v = 0; v < 8; v++) begin
      wr(1, v[7:0]);
      repeat (2) @(posedge pclk);
      check_ctrl();
    end
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      wr(seed[9:8], seed[7:0]);
      repeat (2) @(posedge pclk);
      check_ctrl();
      rdchk(seed[9:8]);
    end
    apb(1'b1, 10'h07E, 8'hA5, d, e);
    chk(e, 1'b1, "unmapped wr");
    apb(1'b0, 10'h07E, 8'h00, d, e);
    chk(d, 32'h00000000, "unmapped rd");
    for (int k = 0; k < 4; k++)
      rdchk(k);
    $display("test access done");
    // link off first, as the host must before touching link setup
    // and before it may drop its calibration enable
    wr(3, 8'h00);
    repeat (3) @(posedge pclk);
    check_ctrl();
    repeat (40) begin
      @(posedge pclk);
      chk(mf_count, 8'h00, "counter");
    end
    // status: counter 0, fuse loaded, link held in reset
    apb(1'b0, CMCR_IDX_STATUS, 8'h00, d, e);
    chk(d, 32'h00000100, "status");
    chk(e, 1'b0, "status err");
    // calibration enable is assumed on before the link returns
    wr(3, 8'h01);
    repeat (3) @(posedge pclk);
    check_ctrl();
    $display("test link done");
    // freeze: with ce low the running counter and samples hold still
    ce <= 1'b0;
    @(posedge pclk);
    snap = {mf_count, sample_out};
    repeat (5) begin
      @(posedge pclk);
      chk({mf_count, sample_out}, snap, "frozen");
    end
    ce <= 1'b1;
    $display("test freeze done");
    // both sample widths, marker off and on; the sync receiver enable
    // sits outside this bank and is assumed set with the marker
    for (int i = 0; i < 4; i++) begin
      sample_8bit <= i[1];
      wr(2, {7'h00, i[0]});
      ts_on = i[0];
      repeat (12) @(posedge pclk);
      cmp_on = 1'b1;
      repeat (40) @(posedge pclk);
      cmp_on = 1'b0;
    end
    $display("test stream done");
    summarize();
  end
endmodule
`default_nettype wire

// ---- logic/cmcr_bank.sv ----
// converter misc control register bank with apb slave
// Operation
// - input b termination trim, fused reset, rw
// - dither enable bit, resets to one
// - dither amplitude select, small at reset
// - rounding residue to noise or offset
// - timestamp replaces output sample lsb
// - marker delayed two cycles more than samples, by its synchroniser
// - marker on lsb, 8 or 12 bit
// - lane alignment control bits stay zero
// - link enable bit, resets to one
// - link disabled: reset, power down, gate
// - disabled: counter reset, sysref ignored
// - upper bits stored, reset to zero
`timescale 1ns/1ns
`default_nettype none
module cmcr_bank
  import cmcr_pkg::*;
(
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [CMCR_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // factory fuse value for the trim, stable from power up
  input wire logic [7:0] fuse_trim_b,
  // sample path
  input wire logic [CMCR_SAMPLE_W-1:0] sample_in,
  input wire logic sample_8bit,
  input wire logic timestamp_pin,
  input wire logic sysref_pin,
  output logic [CMCR_SAMPLE_W-1:0] sample_out,
  // analogue and link controls
  output logic [7:0] input_b_termination_trim_field,
  output logic dither_enable_bit,
  output logic dither_amplitude_select,
  output logic dither_rounding_select,
  output logic link_reset_n,
  output logic serializer_power_down,
  output logic link_clock_enable,
  output logic [1:0] ila_control_bits,
  output logic [7:0] multiframe_counter
);
  // ****************************************
  // storage
  // ****************************************
  logic [7:0] trim_b; // termination trim
  logic [7:0] dither_control; // dither controls
  logic [7:0] sample_lsb_control; // marker insertion control
  logic [7:0] serial_link_enable; // link enable
  logic fuse_loaded; // trim taken from fuses after reset
  logic ts_sync, sysref_sync; // synchronised pins
  logic sysref_prev; // for sysref rising edge
  logic [CMCR_SAMPLE_W:0] delayed; // marker plus sample
  logic [CMCR_SAMPLE_W-1:0] next_sample; // sample after marker
  logic wr_en, rd_en; // write strobe in access phase, read strobe in setup phase
  logic [9:0] idx; // word index

  // word index of the access; low two bits ignored
  function automatic logic [9:0] word_index(
    input logic [CMCR_ADDR_W-1:0] a
  );
    word_index = a[CMCR_ADDR_W-1:2];
  endfunction

  assign idx = word_index(paddr);
  assign wr_en = psel && penable && pwrite && ce;
  assign rd_en = psel && !penable && !pwrite && ce;

  // ****************************************
  // pin synchronisers
  // ****************************************
  cmcr_sync2 u_ts_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .d(timestamp_pin),
    .q(ts_sync)
  );

  cmcr_sync2 u_sysref_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .d(sysref_pin),
    .q(sysref_sync)
  );

  // ****************************************
  // register writes
  // ****************************************
  // trim: fuse value loaded once after reset release, then writable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_b <= 8'h00;
      fuse_loaded <= 1'b0;
    end else if (ce) begin
      if (!fuse_loaded) begin
        trim_b <= fuse_trim_b;
        fuse_loaded <= 1'b1;
      end else if (wr_en && idx == CMCR_IDX_TRIM_B) begin
        trim_b <= pwdata[7:0];
      end
    end
  end

  // dither control, all eight bits stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dither_control <= CMCR_RST_DITHER;
    end else if (wr_en && idx == CMCR_IDX_DITHER) begin
      dither_control <= pwdata[7:0];
    end
  end

  // sample lsb control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_lsb_control <= CMCR_RST_LSB_CTRL;
    end else if (wr_en && idx == CMCR_IDX_LSB_CTRL) begin
      sample_lsb_control <= pwdata[7:0];
    end
  end

  // link enable; software is expected to order calibration itself
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_link_enable <= CMCR_RST_LINK_EN;
    end else if (wr_en && idx == CMCR_IDX_LINK_EN) begin
      serial_link_enable <= pwdata[7:0];
    end
  end

  // ****************************************
  // apb answer
  // ****************************************
  // read data captured in setup so it is registered during access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      if (idx == CMCR_IDX_TRIM_B) begin
        prdata <= {24'h000000, trim_b};
      end else if (idx == CMCR_IDX_DITHER) begin
        prdata <= {24'h000000, dither_control};
      end else if (idx == CMCR_IDX_LSB_CTRL) begin
        prdata <= {24'h000000, sample_lsb_control};
      end else if (idx == CMCR_IDX_LINK_EN) begin
        prdata <= {24'h000000, serial_link_enable};
      end else if (idx == CMCR_IDX_STATUS) begin
        prdata <= {22'h0, link_reset_n, fuse_loaded,
                   multiframe_counter};
      end else begin
        prdata <= 32'h0000_0000; // unmapped reads zero
      end
    end
  end

  // zero wait states; error flagged on unmapped index
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= psel && !penable;
      pslverr <= psel && !penable &&
                 idx != CMCR_IDX_TRIM_B && idx != CMCR_IDX_DITHER &&
                 idx != CMCR_IDX_LSB_CTRL && idx != CMCR_IDX_LINK_EN &&
                 idx != CMCR_IDX_STATUS;
    end
  end

  // ****************************************
  // control outputs
  // ****************************************
  // analogue and link controls registered from storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_b_termination_trim_field <= 8'h00;
      dither_enable_bit <= CMCR_RST_DITHER[CMCR_DITH_EN_POS];
      dither_amplitude_select <= CMCR_RST_DITHER[CMCR_DITH_AMP_POS];
      dither_rounding_select <= CMCR_RST_DITHER[CMCR_DITH_RND_POS];
      link_reset_n <= 1'b0;
      serializer_power_down <= 1'b1;
      link_clock_enable <= 1'b0;
      ila_control_bits <= CMCR_ILA_CS;
    end else if (ce) begin
      input_b_termination_trim_field <= trim_b;
      dither_enable_bit <= dither_control[CMCR_DITH_EN_POS];
      dither_amplitude_select <= dither_control[CMCR_DITH_AMP_POS];
      // 0 residue into noise, 1 into offset and spurs
      dither_rounding_select <= dither_control[CMCR_DITH_RND_POS];
      // link held in reset, powered down and unclocked while off
      link_reset_n <= serial_link_enable[CMCR_LINK_EN_POS];
      serializer_power_down <= !serial_link_enable[CMCR_LINK_EN_POS];
      link_clock_enable <= serial_link_enable[CMCR_LINK_EN_POS];
      ila_control_bits <= CMCR_ILA_CS;
    end
  end

  // ****************************************
  // multiframe counter
  // ****************************************
  // held at zero while link off; sysref cannot realign it then
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      multiframe_counter <= 8'h00;
      sysref_prev <= 1'b0;
    end else if (ce) begin
      sysref_prev <= sysref_sync;
      if (!serial_link_enable[CMCR_LINK_EN_POS]) begin
        multiframe_counter <= 8'h00;
      end else if (sysref_sync && !sysref_prev) begin
        multiframe_counter <= 8'h00;
      end else if (multiframe_counter == CMCR_MF_LAST) begin
        multiframe_counter <= 8'h00;
      end else begin
        multiframe_counter <= multiframe_counter + 8'h01;
      end
    end
  end

  // ****************************************
  // timestamp marker path
  // ****************************************
  // marker rides the same pipe as the sample, two cycles behind it from its synchroniser
  cmcr_delay_line #(
    .WIDTH(CMCR_SAMPLE_W + 1),
    .DEPTH(CMCR_PIPE_LAT)
  ) u_pipe (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .din({ts_sync, sample_in}),
    .dout(delayed)
  );

  // lsb of the active width replaced; 8-bit samples sit in the top byte
  always_comb begin
    next_sample = delayed[CMCR_SAMPLE_W-1:0];
    if (sample_lsb_control[CMCR_TS_EN_POS]) begin
      if (sample_8bit) begin
        next_sample[4] = delayed[CMCR_SAMPLE_W];
      end else begin
        next_sample[0] = delayed[CMCR_SAMPLE_W];
      end
    end
  end

  // output sample register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_out <= '0;
    end else if (ce) begin
      sample_out <= next_sample;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  // the gate output leaves reset low one edge after the enable leaves it
  // high, so the edge straight after reset release is skipped
  chk_link_gating: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && $past(ce) && $past(presetn) |-> link_clock_enable ==
      $past(serial_link_enable[CMCR_LINK_EN_POS]))
    else $error("link gating does not follow enable");
  chk_counter_held: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && !serial_link_enable[CMCR_LINK_EN_POS] |=>
      multiframe_counter == 8'h00)
    else $error("counter moved while link off");
  chk_ila_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    ila_control_bits == 2'h0)
    else $error("control bits advertised");
  chk_dither_en: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && $past(ce) |-> dither_enable_bit == $past(dither_control[0]))
    else $error("dither enable mismatch");
  chk_dither_amp: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && $past(ce) |-> dither_amplitude_select == $past(dither_control[1]))
    else $error("dither amplitude mismatch");
  chk_dither_rnd: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && $past(ce) |-> dither_rounding_select == $past(dither_control[2]))
    else $error("rounding select mismatch");
  chk_marker_lsb: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && sample_lsb_control[0] && !sample_8bit |=>
      sample_out[0] == $past(delayed[CMCR_SAMPLE_W]))
    else $error("marker not on lsb");
  chk_trim_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_en && fuse_loaded && idx == CMCR_IDX_TRIM_B |=> ##1
      input_b_termination_trim_field == $past(pwdata[7:0], 2))
    else $error("trim write not seen");
  chk_upper_store: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_en && idx == CMCR_IDX_LINK_EN |=>
      serial_link_enable == $past(pwdata[7:0]))
    else $error("upper bits not stored");
endmodule
`default_nettype wire

// ---- logic/cmcr_delay_line.sv ----
// fixed-latency delay line for sample words and their marker
`timescale 1ns/1ns
`default_nettype none
module cmcr_delay_line
  import cmcr_pkg::*;
#(
  parameter int WIDTH = 13,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  // ****************************************
  // shift stages
  // ****************************************
  logic [WIDTH-1:0] stage [DEPTH]; // one word per stage

  // advance every stage when enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        stage[i] <= '0;
      end
    end else if (ce) begin
      stage[0] <= din;
      for (int i = 1; i < DEPTH; i++) begin
        stage[i] <= stage[i-1];
      end
    end
  end

  assign dout = stage[DEPTH-1];
endmodule
`default_nettype wire

// ---- logic/cmcr_sync2.sv ----
// two flip-flop level synchroniser
`timescale 1ns/1ns
`default_nettype none
module cmcr_sync2 (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // level
  input wire logic d,
  output logic q
);
  logic meta; // first stage, read only by the second

  // two stages; metastability settles in the first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= 1'b0;
      q <= 1'b0;
    end else if (ce) begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

// ---- shared/cmcr_pkg.sv ----
// package of offsets, field positions, reset values and counts for the bank
package cmcr_pkg;
  // ****************************************
  // register word indices
  // ****************************************
  // 0x7F and 0x9D are not multiples of four, so offsets are indices
  localparam logic [9:0] CMCR_IDX_TRIM_B = 10'h07F;
  localparam logic [9:0] CMCR_IDX_DITHER = 10'h09D;
  localparam logic [9:0] CMCR_IDX_LSB_CTRL = 10'h160;
  localparam logic [9:0] CMCR_IDX_LINK_EN = 10'h200;
  // my own status register, reads back live block state
  localparam logic [9:0] CMCR_IDX_STATUS = 10'h201;
  localparam int CMCR_ADDR_W = 12;
  // ****************************************
  // field positions
  // ****************************************
  localparam int CMCR_DITH_EN_POS = 0;
  localparam int CMCR_DITH_AMP_POS = 1;
  localparam int CMCR_DITH_RND_POS = 2;
  localparam int CMCR_TS_EN_POS = 0;
  localparam int CMCR_LINK_EN_POS = 0;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] CMCR_RST_DITHER = 8'h01;
  localparam logic [7:0] CMCR_RST_LSB_CTRL = 8'h00;
  localparam logic [7:0] CMCR_RST_LINK_EN = 8'h01;
  // ****************************************
  // sample path
  // ****************************************
  localparam int CMCR_SAMPLE_W = 12;
  // sample delay line depth in clock cycles; the output register adds one more
  localparam int CMCR_PIPE_LAT = 4;
  // control bits per sample advertised in lane alignment
  localparam logic [1:0] CMCR_ILA_CS = 2'h0;
  // last multiframe counter value; the period is 32 clock cycles
  localparam logic [7:0] CMCR_MF_LAST = 8'h1F;
endpackage
